//--- hw/rlt_core_regs.sv
// Core register bank: lock-protected test controls and channel alarms.
`timescale 1ns/1ps
`default_nettype none
`include "rlt_defs.svh"
module rlt_core_regs
    import rlt_pkg::*;
#(
    parameter int NCH = 4
) (
    input wire logic CLK_SYS, // Core reference clock, 100 MHz.
    input wire logic NRST, // Asynchronous reset, active low.
    input wire logic BUS_STB, // One-cycle access strobe.
    input wire logic BUS_RNW, // High read, low write.
    input wire logic [17:0] BUS_ADDR, // System bus byte address.
    input wire logic [7:0] BUS_WDATA, // Write data.
    output logic BUS_ACK, // One-cycle answer pulse.
    output logic [7:0] BUS_RDATA, // Read data, valid with BUS_ACK.
    output logic BUS_RPAR, // Read parity line, always low.
    output logic WR_DENIED, // Sticky refused-write flag.
    output logic LOOPBACK_EN, // Backplane loopback enable.
    output logic PARITY_EVEN, // Parallel bus parity: high even.
    output logic SCRAMBLE_EN, // Scrambler and descrambler enable.
    input wire logic [NCH-1:0] ALARM_IN, // Raw channel alarms.
    input wire logic [8*NCH-1:0] TX_DATA, // Transmit bytes per channel.
    input wire logic [NCH-1:0] TX_IS_A1, // Byte is an A1 byte.
    input wire logic [NCH-1:0] TX_IS_A2, // Byte is an A2 byte.
    input wire logic [NCH-1:0] TX_IS_B1, // Byte is the B1 byte.
    output logic [8*NCH-1:0] TX_DATA_OUT // Transmit bytes after insertion.
);
    rlt_top_s state_reg;
    rlt_top_s state_next;
    logic [NCH-1:0] done;
    logic [NCH-1:0] cmd_clr;
    logic unlocked;
    logic wr;
    logic rd;

    // -------------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------------
    function automatic logic hit(input logic [17:0] a,
                                 input logic [17:0] target);
        hit = (a == target);
    endfunction

    // Reset image of every register.
    function automatic rlt_top_s reset_image();
        rlt_top_s r;
        r = '0;
        r.lock = `RLT_LOCK_RST;
        r.ctrl = `RLT_CTRL_RST;
        reset_image = r;
    endfunction

    assign wr = BUS_STB && !BUS_RNW;
    assign rd = BUS_STB && BUS_RNW;
    assign unlocked = (state_reg.lock == `RLT_LOCK_KEY);

    // -------------------------------------------------------------------
    // Register update
    // -------------------------------------------------------------------
    // The lock register itself must stay writable, or a locked part could
    // never be opened; the scratch pad is the other exemption.
    always_comb begin
        state_next = state_reg;
        state_next.ack = BUS_STB;
        state_next.rpar = 1'b0;
        state_next.arm = '0;
        state_next.alarm = ALARM_IN & state_reg.alarm_en;
        // Hardware ends a command when its frames are done.
        state_next.cmd = state_reg.cmd & ~cmd_clr;
        if (rd && hit(BUS_ADDR, `RLT_A_STATUS)) begin
            state_next.err = 1'b0;
        end
        if (wr) begin
            if (hit(BUS_ADDR, `RLT_A_SCRATCH)) begin
                state_next.scratch = BUS_WDATA;
            end else if (hit(BUS_ADDR, `RLT_A_LOCK_HI)) begin
                state_next.lock[15:8] = BUS_WDATA;
            end else if (hit(BUS_ADDR, `RLT_A_LOCK_LO)) begin
                state_next.lock[7:0] = BUS_WDATA;
            end else if (!unlocked) begin
                state_next.err = 1'b1;
            end else if (hit(BUS_ADDR, `RLT_A_SOFT_RST)) begin
                if (BUS_WDATA[`RLT_SOFT_RST_BIT]) begin
                    state_next = reset_image();
                    state_next.ack = 1'b1;
                end
            end else if (hit(BUS_ADDR, `RLT_A_INS_CMD)) begin
                state_next.cmd = BUS_WDATA[NCH-1:0];
                state_next.arm = BUS_WDATA[NCH-1:0] & ~state_reg.cmd;
            end else if (hit(BUS_ADDR, `RLT_A_FRAME_CTRL)) begin
                state_next.ctrl = BUS_WDATA[6:0];
            end else if (hit(BUS_ADDR, `RLT_A_A1_VAL)) begin
                state_next.a1 = BUS_WDATA;
            end else if (hit(BUS_ADDR, `RLT_A_A2_VAL)) begin
                state_next.a2 = BUS_WDATA;
            end else if (hit(BUS_ADDR, `RLT_A_B1_MASK)) begin
                state_next.b1 = BUS_WDATA;
            end else if (hit(BUS_ADDR, `RLT_A_ALARM_EN)) begin
                state_next.alarm_en = BUS_WDATA[NCH-1:0];
            end
        end
        // Read mux: write-only soft reset and unmapped offsets read zero.
        state_next.rdata = 8'h00;
        if (rd) begin
            unique case (1'b1)
                hit(BUS_ADDR, `RLT_A_LOCK_HI):
                    state_next.rdata = state_reg.lock[15:8];
                hit(BUS_ADDR, `RLT_A_LOCK_LO):
                    state_next.rdata = state_reg.lock[7:0];
                hit(BUS_ADDR, `RLT_A_SCRATCH):
                    state_next.rdata = state_reg.scratch;
                hit(BUS_ADDR, `RLT_A_INS_CMD):
                    state_next.rdata = {4'h0, state_reg.cmd};
                hit(BUS_ADDR, `RLT_A_STATUS):
                    state_next.rdata = {7'h00, state_reg.err};
                hit(BUS_ADDR, `RLT_A_FRAME_CTRL):
                    state_next.rdata = {1'b0, state_reg.ctrl};
                hit(BUS_ADDR, `RLT_A_A1_VAL):
                    state_next.rdata = state_reg.a1;
                hit(BUS_ADDR, `RLT_A_A2_VAL):
                    state_next.rdata = state_reg.a2;
                hit(BUS_ADDR, `RLT_A_B1_MASK):
                    state_next.rdata = state_reg.b1;
                hit(BUS_ADDR, `RLT_A_ALARM):
                    state_next.rdata = {4'h0, state_reg.alarm};
                hit(BUS_ADDR, `RLT_A_ALARM_EN):
                    state_next.rdata = {4'h0, state_reg.alarm_en};
                default:
                    state_next.rdata = 8'h00;
            endcase
        end
    end

    // Every register runs on the core reference clock alone.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            state_reg <= reset_image();
        end else begin
            state_reg <= state_next;
        end
    end

    // -------------------------------------------------------------------
    // Channel inserters
    // -------------------------------------------------------------------
    // All channels share one structure and one set of insert values.
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            rlt_ins_if ch_if ();
            assign ch_if.a1 = state_reg.a1;
            assign ch_if.a2 = state_reg.a2;
            assign ch_if.b1 = state_reg.b1;
            assign ch_if.count = state_reg.ctrl[`RLT_CTRL_CNT_MSB:0];
            assign ch_if.arm = state_reg.arm[g];
            assign ch_if.data_in = TX_DATA[8*g +: 8];
            assign ch_if.is_a1 = TX_IS_A1[g];
            assign ch_if.is_a2 = TX_IS_A2[g];
            assign ch_if.is_b1 = TX_IS_B1[g];
            assign done[g] = ch_if.done;
            // A fresh arm in flight outranks the clear of the old run.
            // Only registered state is read here, so no loop through the
            // next-state logic can form.
            assign cmd_clr[g] = done[g] && !state_reg.arm[g];
            assign TX_DATA_OUT[8*g +: 8] = ch_if.data_out;
            rlt_ins u_ins (
                .clk_sys(CLK_SYS),
                .nrst(NRST),
                .port_i(ch_if.ins)
            );
        end
    endgenerate

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign BUS_ACK = state_reg.ack;
    assign BUS_RDATA = state_reg.rdata;
    assign BUS_RPAR = state_reg.rpar;
    assign WR_DENIED = state_reg.err;
    assign LOOPBACK_EN = state_reg.ctrl[`RLT_CTRL_LOOP];
    assign PARITY_EVEN = state_reg.ctrl[`RLT_CTRL_PAR];
    assign SCRAMBLE_EN = state_reg.ctrl[`RLT_CTRL_SCR];
endmodule
`default_nettype wire

//--- hw/rlt_defs.svh
// Constants of the core register bank: offsets, fields, reset values.
`ifndef RLT_DEFS_SVH
`define RLT_DEFS_SVH
`define RLT_ADDR_W 18
`define RLT_CORE_BASE 18'h30000
`define RLT_A_LOCK_HI 18'h30004
`define RLT_A_LOCK_LO 18'h30005
`define RLT_A_SCRATCH 18'h30006
`define RLT_A_SOFT_RST 18'h30007
`define RLT_A_INS_CMD 18'h3000a
`define RLT_A_STATUS 18'h3000b
`define RLT_A_FRAME_CTRL 18'h3000c
`define RLT_A_A1_VAL 18'h3000d
`define RLT_A_A2_VAL 18'h3000e
`define RLT_A_B1_MASK 18'h3000f
`define RLT_A_ALARM 18'h30010
`define RLT_A_ALARM_EN 18'h30011
`define RLT_LOCK_KEY 16'h0580
`define RLT_LOCK_RST 16'h0000
`define RLT_CTRL_RST 7'h60
`define RLT_CTRL_CNT_MSB 3
`define RLT_CTRL_LOOP 4
`define RLT_CTRL_PAR 5
`define RLT_CTRL_SCR 6
`define RLT_SOFT_RST_BIT 0
`define RLT_STATUS_ERR_BIT 0
`endif

//--- hw/rlt_pkg.sv
// Types shared by the core register bank and its channel inserters.
package rlt_pkg;
    typedef struct packed {
        logic [15:0] lock;
        logic [7:0] scratch;
        logic [6:0] ctrl;
        logic [3:0] cmd;
        logic [3:0] arm;
        logic [7:0] a1;
        logic [7:0] a2;
        logic [7:0] b1;
        logic [3:0] alarm;
        logic [3:0] alarm_en;
        logic err;
        logic ack;
        logic [7:0] rdata;
        logic rpar;
    } rlt_top_s;
    typedef struct packed {
        logic [3:0] remaining;
        logic active;
        logic done;
        logic [7:0] data;
    } rlt_ins_s;
endpackage

//--- hw/rlt_ins_if.sv
// Per-channel link between the register bank and one byte inserter.
`timescale 1ns/1ps
`default_nettype none
interface rlt_ins_if;
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] b1;
    logic [3:0] count;
    logic arm;
    logic done;
    logic [7:0] data_in;
    logic is_a1;
    logic is_a2;
    logic is_b1;
    logic [7:0] data_out;
    modport bank (output a1, a2, b1, count, arm, data_in, is_a1, is_a2,
                  is_b1, input done, data_out);
    modport ins (input a1, a2, b1, count, arm, data_in, is_a1, is_a2, is_b1,
                 output done, data_out);
endinterface
`default_nettype wire

//--- hw/rlt_ins.sv
// Transmit byte inserter for one channel: A1/A2 replacement and B1 flip.
`timescale 1ns/1ps
`default_nettype none
`include "rlt_defs.svh"
module rlt_ins
    import rlt_pkg::*;
(
    input wire logic clk_sys, // Core reference clock.
    input wire logic nrst, // Asynchronous reset, active low.
    rlt_ins_if.ins port_i // Settings in, bytes in and out.
);
    rlt_ins_s state_reg;
    rlt_ins_s state_next;

    // A frame counts as corrupted once its A2 byte has been replaced.
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.data = port_i.data_in;
        if (port_i.arm) begin
            state_next.remaining = port_i.count;
            state_next.active = (port_i.count != 4'h0);
            state_next.done = (port_i.count == 4'h0);
        end else if (state_reg.active && port_i.is_a1) begin
            state_next.data = port_i.a1;
        end else if (state_reg.active && port_i.is_a2) begin
            state_next.data = port_i.a2;
            state_next.remaining = state_reg.remaining - 4'h1;
            if (state_reg.remaining == 4'h1) begin
                state_next.active = 1'b0;
                state_next.done = 1'b1;
            end
        end
        if (port_i.is_b1) begin
            state_next.data = port_i.data_in ^ port_i.b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign port_i.done = state_reg.done;
    assign port_i.data_out = state_reg.data;
endmodule
`default_nettype wire

//--- verif/rlt_core_regs_props.sv
// Port assertions for the core register bank.
`timescale 1ns/1ps
`default_nettype none
`include "rlt_defs.svh"
module rlt_core_regs_props (
    input wire logic CLK_SYS, // Core clock.
    input wire logic NRST, // Reset, active low.
    input wire logic BUS_STB, // Access strobe.
    input wire logic BUS_RNW, // High read.
    input wire logic [17:0] BUS_ADDR, // Byte address.
    input wire logic BUS_ACK, // Answer pulse.
    input wire logic [7:0] BUS_RDATA, // Read data.
    input wire logic BUS_RPAR, // Read parity.
    input wire logic WR_DENIED, // Refused-write flag.
    input wire logic LOOPBACK_EN, // Loopback enable.
    input wire logic PARITY_EVEN, // Parity sense.
    input wire logic SCRAMBLE_EN // Scrambler enable.
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    logic rd;
    logic wr;
    assign rd = BUS_STB && BUS_RNW;
    assign wr = BUS_STB && !BUS_RNW;
    a_ack_follows_strobe: assert property (
        BUS_STB |=> BUS_ACK) else $error("Access not answered.");
    a_ack_only_requested: assert property (
        !BUS_STB |=> !BUS_ACK) else $error("Answer without access.");
    a_parity_line_low: assert property (
        BUS_ACK |-> !BUS_RPAR) else $error("Read parity not low.");
    a_denied_flag_sticky: assert property (
        WR_DENIED && !(rd && BUS_ADDR == `RLT_A_STATUS)
        && !(wr && BUS_ADDR == `RLT_A_SOFT_RST) |=> WR_DENIED)
        else $error("Error flag lost.");
    a_unused_addr_zero: assert property (
        rd && BUS_ADDR > `RLT_A_ALARM_EN |=> BUS_RDATA == 8'h00)
        else $error("Unused address read nonzero.");
    a_write_only_zero: assert property (
        rd && BUS_ADDR == `RLT_A_SOFT_RST |=> BUS_RDATA == 8'h00)
        else $error("Write-only register read nonzero.");
    a_alarm_upper_zero: assert property (
        rd && BUS_ADDR == `RLT_A_ALARM |=> BUS_RDATA[7:4] == 4'h0)
        else $error("Alarm upper bits nonzero.");
    a_ctrl_bit7_zero: assert property (
        rd && BUS_ADDR == `RLT_A_FRAME_CTRL |=> !BUS_RDATA[7])
        else $error("Control bit 7 nonzero.");
    a_ctrl_by_write: assert property (
        !$stable({LOOPBACK_EN, PARITY_EVEN, SCRAMBLE_EN}) |->
        $past(wr)) else $error("Control moved alone.");
endmodule
`default_nettype wire

//--- verif/rlt_host_model.sv
// Bus master model issuing single-byte accesses to the core bank.
`timescale 1ns/1ps
`default_nettype none
module rlt_host_model (
    input wire logic clk, // Core clock.
    output logic stb, // Access strobe.
    output logic rnw, // High read.
    output logic [17:0] addr, // Byte address.
    output logic [7:0] wdata, // Write data.
    input wire logic ack, // Answer pulse.
    input wire logic [7:0] rdata // Read data.
);
    // ----------------------------------------
    // Access task
    // ----------------------------------------
    initial begin
        stb = 1'b0;
        rnw = 1'b1;
        addr = 18'h0;
        wdata = 8'h0;
    end
    // Data goes out in processor-port bit order, never byte swapped.
    // A released bus shows inverted values so stale ones never pass.
    task automatic xfer(input logic r, input logic [17:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic ok);
        ok = 1'b0;
        q = 8'h00;
        @(posedge clk);
        stb <= 1'b1;
        rnw <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        stb <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            if (ack === 1'b1) begin
                ok = 1'b1;
                q = rdata;
            end
        end
    endtask
endmodule
`default_nettype wire

//--- verif/core_register_lock_and_test_controls_tb_top.sv
// Self-checking bench for the core register bank.
`timescale 1ns/1ps
`default_nettype none
`include "rlt_defs.svh"
module core_register_lock_and_test_controls_tb_top;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    logic clk = 1'b0, nrst = 1'b0, stb, rnw, ack, rpar, den, lbk, par, scr;
    logic [17:0] addr;
    logic [7:0] wd, rdt;
    logic [3:0] alm = 4'h0, a1 = 4'h0, a2 = 4'h0, b1 = 4'h0;
    logic [31:0] txd = 32'h0, txo;
    int err_count = 0, checks_done = 0;
    always #5 clk = ~clk;
    rlt_core_regs #(.NCH(4)) u_dut (.CLK_SYS(clk), .NRST(nrst),
        .BUS_STB(stb), .BUS_RNW(rnw), .BUS_ADDR(addr), .BUS_WDATA(wd),
        .BUS_ACK(ack), .BUS_RDATA(rdt), .BUS_RPAR(rpar), .WR_DENIED(den),
        .LOOPBACK_EN(lbk), .PARITY_EVEN(par), .SCRAMBLE_EN(scr),
        .ALARM_IN(alm), .TX_DATA(txd), .TX_IS_A1(a1), .TX_IS_A2(a2),
        .TX_IS_B1(b1), .TX_DATA_OUT(txo));
    rlt_host_model u_host (.clk(clk), .stb(stb), .rnw(rnw), .addr(addr),
        .wdata(wd), .ack(ack), .rdata(rdt));
    task automatic results();
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic r, input logic [17:0] a,
        input logic [7:0] d, output logic [7:0] q);
        logic ok;
        u_host.xfer(r, a, d, q, ok);
        if (!ok) begin
            err_count++;
            results();
        end
    endtask
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b0, a, d, q);
    endtask
    task automatic rd_chk(input logic [17:0] a, input logic [7:0] e);
        logic [7:0] q;
        acc(1'b1, a, 8'h00, q);
        chk(q, e);
    endtask
    // Same byte and marks {b1,a2,a1} on every channel; only channel 0 is
    // ever armed, so channel 3 shows the shared mask but no replacement.
    task automatic send(input logic [7:0] b, input logic [2:0] m,
        input logic [7:0] e);
        @(posedge clk);
        txd <= {4{b}};
        {b1, a2, a1} <= {{4{m[2]}}, {4{m[1]}}, {4{m[0]}}};
        @(posedge clk);
        {b1, a2, a1} <= 12'h000;
        #1 chk(txo[7:0], e);
        chk(txo[31:24], m[2] ? e : b);
    endtask
    task automatic t_reset_values();
        rd_chk(`RLT_A_LOCK_HI, 8'h00);
        rd_chk(`RLT_A_LOCK_LO, 8'h00);
        rd_chk(`RLT_A_FRAME_CTRL, 8'h60);
        rd_chk(`RLT_A_A2_VAL, 8'h00);
        rd_chk(`RLT_A_ALARM_EN, 8'h00);
        rd_chk(18'h30020, 8'h00);
    endtask
    task automatic t_lock();
        wr(`RLT_A_A1_VAL, 8'h5a);
        chk({7'h00, den}, 8'h01);
        rd_chk(`RLT_A_A1_VAL, 8'h00);
        wr(`RLT_A_SCRATCH, 8'hc3);
        rd_chk(`RLT_A_SCRATCH, 8'hc3);
        rd_chk(`RLT_A_STATUS, 8'h01);
        rd_chk(`RLT_A_STATUS, 8'h00);
        wr(`RLT_A_LOCK_HI, 8'h05);
        wr(`RLT_A_A1_VAL, 8'h11);
        rd_chk(`RLT_A_A1_VAL, 8'h00);
        wr(`RLT_A_LOCK_LO, 8'h80);
        wr(`RLT_A_A1_VAL, 8'hf6);
        rd_chk(`RLT_A_A1_VAL, 8'hf6);
    endtask
    task automatic t_controls();
        wr(`RLT_A_FRAME_CTRL, 8'h90);
        chk({5'h00, lbk, par, scr}, 8'h04);
        rd_chk(`RLT_A_FRAME_CTRL, 8'h10);
        wr(`RLT_A_FRAME_CTRL, 8'h62);
        chk({5'h00, lbk, par, scr}, 8'h03);
        rd_chk(`RLT_A_SOFT_RST, 8'h00);
        alm <= 4'hf;
        wr(`RLT_A_ALARM_EN, 8'hf5);
        rd_chk(`RLT_A_ALARM_EN, 8'h05);
        rd_chk(`RLT_A_ALARM, 8'h05);
        alm <= 4'h0;
        rd_chk(`RLT_A_ALARM, 8'h00);
    endtask
    task automatic t_insert();
        wr(`RLT_A_B1_MASK, 8'h81);
        send(8'h3c, 3'b100, 8'hbd);
        wr(`RLT_A_A2_VAL, 8'h28);
        wr(`RLT_A_INS_CMD, 8'h01);
        for (int f = 0; f < 3; f++) begin
            send(8'h55, 3'b001, (f < 2) ? 8'hf6 : 8'h55);
            send(8'h55, 3'b010, (f < 2) ? 8'h28 : 8'h55);
        end
        rd_chk(`RLT_A_INS_CMD, 8'h00);
        wr(`RLT_A_SOFT_RST, 8'h01);
        rd_chk(`RLT_A_LOCK_LO, 8'h00);
        rd_chk(`RLT_A_A1_VAL, 8'h00);
        rd_chk(`RLT_A_FRAME_CTRL, 8'h60);
        rd_chk(`RLT_A_STATUS, 8'h00);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_reset_values();
        t_lock();
        t_controls();
        t_insert();
        results();
    end
endmodule
bind rlt_core_regs rlt_core_regs_props u_props (.CLK_SYS(CLK_SYS),
    .NRST(NRST), .BUS_STB(BUS_STB), .BUS_RNW(BUS_RNW), .BUS_ADDR(BUS_ADDR),
    .BUS_ACK(BUS_ACK), .BUS_RDATA(BUS_RDATA), .BUS_RPAR(BUS_RPAR),
    .WR_DENIED(WR_DENIED), .LOOPBACK_EN(LOOPBACK_EN),
    .PARITY_EVEN(PARITY_EVEN), .SCRAMBLE_EN(SCRAMBLE_EN));
`default_nettype wire
